// File: serial_port_pkg.sv
// Package with addresses, field positions and reset values of the serial port block
`default_nettype none
package serial_port_pkg;
	localparam logic [15:0] CONTROL_ADDR    = 16'hfff5;
	localparam logic [15:0] STATUS_ADDR     = 16'hfff6;
	localparam logic [15:0] DIVISOR_ADDR    = 16'hfff7;
	localparam logic [15:0] DIVISOR_RESET   = 16'h0001;
	localparam logic [15:0] CONTROL_RESET   = 16'h0000;
	localparam logic [15:0] CONTROL_WMASK   = 16'he3ff;
	localparam int          PORT_RESET_BIT  = 13;
	localparam int          DELTA_MASK_BIT  = 9;
	localparam int          TX_MASK_BIT     = 8;
	localparam int          RX_MASK_BIT     = 7;
	localparam int          AUTOBAUD_EN_BIT = 5;
	localparam int          AB_DONE_BIT     = 14;
	localparam int          OVERRUN_BIT     = 9;
	localparam int          DATA_READY_BIT  = 8;
	localparam int          FLAG_LSB        = 4;
	localparam int          PIN_COUNT       = 4;
	localparam int          OVERSAMPLE      = 16;
	localparam int          BIT_CNT_W       = 4;
	localparam logic [7:0]  CHAR_UPPER_A    = 8'h41;
	localparam logic [7:0]  CHAR_LOWER_A    = 8'h61;
endpackage
`default_nettype wire

// File: baud_tick_gen.sv
// Divisor counter giving one oversample tick per divisor count
`timescale 1ns/1ps
`default_nettype none
module baud_tick_gen
(
	input  wire logic        mclk_i,
	input  wire logic        rst_i,
	input  wire logic        run_i,
	input  wire logic [15:0] divisor_i,
	output logic             tick_o
);
	typedef struct packed
	{
		logic [15:0] cnt;
		logic        tick;
	} state_type;

	state_type s_q;
	state_type s_d;

	always_comb
	begin
		s_d = s_q;
		s_d.tick = 1'b0;
		// Zero divisor stops the tick, so no character moves
		if (!run_i || divisor_i == 16'h0000)
		begin
			s_d.cnt = 16'h0000;
		end
		else if (s_q.cnt >= divisor_i - 16'h0001)
		begin
			s_d.cnt = 16'h0000;
			s_d.tick = 1'b1;
		end
		else
		begin
			s_d.cnt = s_q.cnt + 16'h0001;
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			s_q <= '0;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	assign tick_o = s_q.tick;

	a_tick_stops_zero : assert property (@(posedge mclk_i) disable iff (rst_i)
		(divisor_i == 16'h0000) [*2] |-> !tick_o)
		else $error("Tick while divisor is zero");
endmodule
`default_nettype wire

// File: serial_port_ctrl.sv
// Divisor, auto-baud lock, pin direction and pin status logic of the serial port
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Change flags set only for input pins while the port runs.
// - A seen change sets the pin flag and, with the delta mask bit set, requests the port interrupt.
// - Writing 1 clears a change flag; writing 0 leaves it alone.
// - Status bits 3..0 read the present level of input pins.
// - Divisor zero stops the oversample tick, so the receiver stops.
// - Divisor register resets to 0001h.
// - Bit period is sixteen divisor-length ticks.
// - First 'A' or 'a' while armed locks rate and writes divisor.
// - Auto-baud success raises the interrupt regardless of masks.
// - Unread character followed by another one sets the overrun flag.
// - While done flag and enable are both set, receive interrupt stays on.
// - Each direction bit makes its pin output when 1, input when 0.
// - All direction bits clear on reset, pins start as inputs.
// - Delta mask bit gates pin change interrupts onto the shared line.
// - Port reset bit low holds the port in reset; resets to 0.
// - Writing a status low bit drives that level on an output pin.
module serial_port_ctrl
(
	input  wire logic        mclk_i,
	input  wire logic        rst_i,
	input  wire logic [15:0] io_addr_i,
	input  wire logic        io_wr_i,
	input  wire logic        io_rd_i,
	input  wire logic [15:0] io_wdata_i,
	output logic      [15:0] io_rdata_o,
	input  wire logic [3:0]  port_pin_i,
	output logic      [3:0]  port_pin_o,
	output logic      [3:0]  port_pin_oe_o,
	input  wire logic        rx_pin_i,
	input  wire logic        char_read_i,
	input  wire logic        other_irq_i,
	output logic      [7:0]  char_data_o,
	output logic             port_irq_line_o,
	output logic             oversample_tick_o
);
	typedef enum logic [1:0] {IDLE, START, DATA, STOP} rx_type;

	typedef struct packed
	{
		logic [15:0] ctrl;
		logic [15:0] divisor;
		logic [3:0]  pin_out;
		logic [3:0]  change;
		logic        ab_done;
		logic        overrun;
		logic        ready;
		logic [7:0]  data;
		logic [3:0]  sync1;
		logic [3:0]  sync2;
		logic [3:0]  prev;
		logic        rx1;
		logic        rx2;
		logic        rx3;
		rx_type      rx;
		logic [3:0]  sub;
		logic [2:0]  nbit;
		logic [7:0]  shift;
		logic [15:0] measure;
		logic        measuring;
		logic [15:0] rdata;
	} state_type;

	state_type s_q;
	state_type s_d;
	logic      tick;
	logic      run;
	logic      wr_ctrl;
	logic      wr_stat;
	logic      wr_div;
	logic      delta_irq;
	logic      rx_irq;
	logic      armed;

	assign run = s_q.ctrl[serial_port_pkg::PORT_RESET_BIT];
	assign armed = s_q.ctrl[serial_port_pkg::AUTOBAUD_EN_BIT] && !s_q.ab_done;
	assign wr_ctrl = io_wr_i && io_addr_i == serial_port_pkg::CONTROL_ADDR;
	assign wr_stat = io_wr_i && io_addr_i == serial_port_pkg::STATUS_ADDR;
	assign wr_div = io_wr_i && io_addr_i == serial_port_pkg::DIVISOR_ADDR;

	baud_tick_gen u_tick
	(
		.mclk_i    (mclk_i),
		.rst_i     (rst_i),
		.run_i     (run),
		.divisor_i (s_q.divisor),
		.tick_o    (tick)
	);

	function automatic logic [15:0] status_word(input state_type s);
		logic [3:0] lvl;
		lvl = (s.sync2 & ~s.ctrl[3:0]) | (s.pin_out & s.ctrl[3:0]);
		status_word = {1'b0, s.ab_done, 4'h0, s.overrun, s.ready, s.change, lvl};
	endfunction

	always_comb
	begin
		s_d = s_q;
		s_d.sync1 = port_pin_i;
		s_d.sync2 = s_q.sync1;
		s_d.prev = s_q.sync2;
		s_d.rx1 = rx_pin_i;
		s_d.rx2 = s_q.rx1;
		s_d.rx3 = s_q.rx2;
		if (wr_ctrl)
		begin
			s_d.ctrl = io_wdata_i & serial_port_pkg::CONTROL_WMASK;
		end
		if (wr_div)
		begin
			s_d.divisor = io_wdata_i;
		end
		if (wr_stat)
		begin
			s_d.pin_out = (io_wdata_i[3:0] & s_q.ctrl[3:0]) | (s_q.pin_out & ~s_q.ctrl[3:0]);
			s_d.change = s_q.change & ~io_wdata_i[7:4];
			if (io_wdata_i[serial_port_pkg::AB_DONE_BIT])
			begin
				s_d.ab_done = 1'b0;
			end
			if (io_wdata_i[serial_port_pkg::OVERRUN_BIT])
			begin
				s_d.overrun = 1'b0;
			end
		end
		if (char_read_i)
		begin
			s_d.ready = 1'b0;
		end
		// Set placed after clear so a same-cycle change is kept
		if (run)
		begin
			s_d.change = s_d.change | ((s_q.sync2 ^ s_q.prev) & ~s_q.ctrl[3:0]);
		end
		if (s_q.measuring)
		begin
			s_d.measure = s_q.measure + 16'h0001;
		end
		if (tick)
		begin
			s_d.sub = s_q.sub + 4'h1;
			case (s_q.rx)
				IDLE:
				begin
					s_d.sub = 4'h0;
					if (!s_q.rx2)
					begin
						s_d.rx = START;
						s_d.measuring = armed;
						s_d.measure = 16'h0000;
					end
				end
				START:
				begin
					if (s_q.sub == 4'(serial_port_pkg::OVERSAMPLE / 2 - 1))
					begin
						s_d.sub = 4'h0;
						s_d.rx = s_q.rx2 ? IDLE : DATA;
						s_d.nbit = 3'h0;
					end
				end
				DATA:
				begin
					if (s_q.sub == 4'(serial_port_pkg::OVERSAMPLE - 1))
					begin
						s_d.shift = {s_q.rx2, s_q.shift[7:1]};
						s_d.nbit = s_q.nbit + 3'h1;
						if (s_q.nbit == 3'h7)
						begin
							s_d.rx = STOP;
						end
					end
				end
				STOP:
				begin
					if (s_q.sub == 4'(serial_port_pkg::OVERSAMPLE - 1))
					begin
						s_d.rx = IDLE;
						s_d.data = s_q.shift;
						s_d.ready = 1'b1;
						if (s_q.ready)
						begin
							s_d.overrun = 1'b1;
						end
						if (s_q.ctrl[serial_port_pkg::AUTOBAUD_EN_BIT] && !s_q.ab_done &&
							(s_q.shift == serial_port_pkg::CHAR_UPPER_A ||
							s_q.shift == serial_port_pkg::CHAR_LOWER_A))
						begin
							s_d.ab_done = 1'b1;
						end
					end
				end
				default:
				begin
					s_d.rx = IDLE;
				end
			endcase
		end
		// Old rate cannot sample the host, so start plus bit 0 are timed edge to edge
		if (armed && s_q.measuring && s_q.rx3 && !s_q.rx2)
		begin
			s_d.measuring = 1'b0;
			s_d.divisor = (s_q.measure + 16'h0011) >> 5;
			s_d.rx = DATA;
			s_d.nbit = 3'h1;
			s_d.shift = 8'h80;
			s_d.sub = 4'h8;
		end
		else if (armed && s_q.measuring)
		begin
			s_d.rx = START;
			s_d.sub = 4'h0;
		end
		if (!run)
		begin
			s_d.rx = IDLE;
			s_d.measuring = 1'b0;
		end
		s_d.rdata = 16'h0000;
		if (io_rd_i)
		begin
			if (io_addr_i == serial_port_pkg::CONTROL_ADDR)
			begin
				s_d.rdata = s_q.ctrl;
			end
			else if (io_addr_i == serial_port_pkg::STATUS_ADDR)
			begin
				s_d.rdata = status_word(s_q);
			end
			else if (io_addr_i == serial_port_pkg::DIVISOR_ADDR)
			begin
				s_d.rdata = s_q.divisor;
			end
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			s_q <= '0;
			s_q.ctrl <= serial_port_pkg::CONTROL_RESET;
			s_q.divisor <= serial_port_pkg::DIVISOR_RESET;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	assign delta_irq = s_q.ctrl[serial_port_pkg::DELTA_MASK_BIT] && |s_q.change;
	assign rx_irq = (s_q.ctrl[serial_port_pkg::RX_MASK_BIT] && (s_q.ready || s_q.overrun)) ||
		(s_q.ab_done && s_q.ctrl[serial_port_pkg::AUTOBAUD_EN_BIT]);
	assign port_irq_line_o = delta_irq || rx_irq || other_irq_i;
	assign port_pin_oe_o = s_q.ctrl[3:0];
	assign port_pin_o = s_q.pin_out;
	assign io_rdata_o = s_q.rdata;
	assign char_data_o = s_q.data;
	assign oversample_tick_o = tick;

	sequence pin_changed(int i);
		s_q.sync2[i] != s_q.prev[i];
	endsequence

	a_change_sets_flag : assert property (@(posedge mclk_i) disable iff (rst_i)
		pin_changed(0) and run and !s_q.ctrl[0] |=> s_q.change[0])
		else $error("Pin change did not set flag");
	a_flag_needs_input : assert property (@(posedge mclk_i) disable iff (rst_i)
		$rose(s_q.change[1]) |-> $past(run) && !$past(s_q.ctrl[1]))
		else $error("Flag set on output pin or stopped port");
	a_clear_on_one : assert property (@(posedge mclk_i) disable iff (rst_i)
		wr_stat && io_wdata_i[6] && s_q.sync2[2] == s_q.prev[2] |=> !s_q.change[2])
		else $error("Write one did not clear flag");
	a_delta_irq : assert property (@(posedge mclk_i) disable iff (rst_i)
		s_q.ctrl[9] && |s_q.change |-> port_irq_line_o)
		else $error("Delta change not on interrupt");
	a_autobaud_irq : assert property (@(posedge mclk_i) disable iff (rst_i)
		s_q.ab_done && s_q.ctrl[5] |-> port_irq_line_o)
		else $error("Auto-baud interrupt missing");
	a_pin_drive : assert property (@(posedge mclk_i) disable iff (rst_i)
		wr_stat && s_q.ctrl[3] |=> port_pin_o[3] == $past(io_wdata_i[3]))
		else $error("Output pin not updated");
	a_dir_follow : assert property (@(posedge mclk_i) disable iff (rst_i)
		wr_ctrl |=> port_pin_oe_o == $past(io_wdata_i[3:0]))
		else $error("Direction not taken");
	a_reset_values : assert property (@(posedge mclk_i)
		rst_i |=> s_q.divisor == 16'h0001 && port_pin_oe_o == 4'h0 && !run)
		else $error("Bad reset values");
endmodule
`default_nettype wire

// File: serial_host_model.sv
// Remote serial host and external pin drivers facing the serial port
`timescale 1ns/1ps
`default_nettype none
module serial_host_model
(
	input  wire logic       mclk_i,
	output logic            rx_pin_o,
	output logic      [3:0] pin_lvl_o
);
	initial
	begin
		rx_pin_o = 1'b1;
		pin_lvl_o = 4'h0;
	end
	// 8N1, LSB first; the line idles high, its stop level, between frames
	task automatic send_char(input logic [7:0] ch, input int bit_cycles);
		logic [9:0] frame;
		frame = {1'b1, ch, 1'b0};
		for (int i = 0; i < 10; i++)
		begin
			@(negedge mclk_i);
			rx_pin_o = frame[i];
			repeat (bit_cycles - 1) @(negedge mclk_i);
		end
		@(negedge mclk_i);
	endtask
	task automatic set_pins(input logic [3:0] v);
		@(negedge mclk_i);
		pin_lvl_o = v;
	endtask
endmodule
`default_nettype wire

// File: tb_uart_baud_autobaud_pin_logic.sv
// Self-checking bench for the divisor, auto-baud and port pin logic
`timescale 1ns/1ps
`default_nettype none
module tb_uart_baud_autobaud_pin_logic;
	localparam logic [15:0] CA = serial_port_pkg::CONTROL_ADDR;
	localparam logic [15:0] SA = serial_port_pkg::STATUS_ADDR;
	localparam logic [15:0] DA = serial_port_pkg::DIVISOR_ADDR;
	localparam int          LIMIT = 20000;
	typedef struct packed {logic [15:0] a; logic [15:0] w; logic [15:0] e; logic [3:0] oe;} row_type;
	logic        mclk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic [15:0] io_addr_i = 16'h0000;
	logic [15:0] io_wdata_i = 16'h0000;
	logic        io_wr_i = 1'b0;
	logic        io_rd_i = 1'b0;
	logic        char_read_i = 1'b0;
	logic        other_irq_i = 1'b0;
	logic [15:0] io_rdata_o;
	logic [15:0] rv;
	logic [3:0]  pin_w;
	logic [3:0]  pin_lvl;
	logic [3:0]  port_pin_o;
	logic [3:0]  port_pin_oe_o;
	logic [3:0]  irq4;
	logic [7:0]  char_data_o;
	logic        rx_w;
	logic        port_irq_line_o;
	logic        oversample_tick_o;
	int          n_fail = 0;
	int          n_compared = 0;
	int          cycles = 0;
	int          k;
	row_type     rows [4] = '{
		'{DA, 16'h0082, 16'h0082, 4'h0},
		'{CA, 16'hffff, 16'he3ff, 4'hf},
		'{CA, 16'h2005, 16'h2005, 4'h5},
		'{16'hfff4, 16'h1234, 16'h0000, 4'h5}};
	// A driven pin shows the design's level, an input pin the far side's
	assign pin_w = (port_pin_oe_o & port_pin_o) | (~port_pin_oe_o & pin_lvl);
	assign irq4 = {3'b000, port_irq_line_o};
	serial_port_ctrl serial_port_ctrl_inst (.mclk_i(mclk_i), .rst_i(rst_i),
		.io_addr_i(io_addr_i), .io_wr_i(io_wr_i), .io_rd_i(io_rd_i),
		.io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o), .port_pin_i(pin_w),
		.port_pin_o(port_pin_o), .port_pin_oe_o(port_pin_oe_o), .rx_pin_i(rx_w),
		.char_read_i(char_read_i), .other_irq_i(other_irq_i), .char_data_o(char_data_o),
		.port_irq_line_o(port_irq_line_o), .oversample_tick_o(oversample_tick_o));
	serial_host_model serial_host_model_inst (.mclk_i(mclk_i), .rx_pin_o(rx_w),
		.pin_lvl_o(pin_lvl));
	always #25 mclk_i = ~mclk_i;
	task automatic complete_run;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge mclk_i)
	begin
		cycles++;
		if (cycles == LIMIT)
		begin
			n_fail++;
			complete_run;
		end
	end
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(negedge mclk_i);
		io_addr_i = a;
		io_wdata_i = d;
		io_wr_i = 1'b1;
		@(negedge mclk_i);
		io_wr_i = 1'b0;
	endtask
	task automatic rd(input logic [15:0] a);
		@(negedge mclk_i);
		io_addr_i = a;
		io_rd_i = 1'b1;
		@(negedge mclk_i);
		io_rd_i = 1'b0;
		rv = io_rdata_o;
	endtask
	task automatic chk_r(input string n, input logic [15:0] e, input logic [15:0] g);
		n_compared++;
		if (g !== e)
		begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chk_s(input string n, input logic [3:0] e, input logic [3:0] g);
		n_compared++;
		if (g !== e)
		begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic ticks(input int n);
		k = 0;
		repeat (n)
		begin
			@(negedge mclk_i);
			if (oversample_tick_o === 1'b1)
				k++;
		end
	endtask
	task automatic do_reset;
		@(negedge mclk_i);
		rst_i = 1'b1;
		repeat (5) @(negedge mclk_i);
		rst_i = 1'b0;
	endtask
	task automatic wait_irq;
		for (int i = 0; i < 300 && port_irq_line_o !== 1'b1; i++) @(negedge mclk_i);
	endtask
	initial
	begin
		do_reset;
		foreach (rows[i])
		begin
			wr(rows[i].a, rows[i].w);
			rd(rows[i].a);
			chk_r("readback", rows[i].e, rv);
			chk_s("pin_oe", rows[i].oe, port_pin_oe_o);
		end
		do_reset;
		rd(DA);
		chk_r("div_reset", 16'h0001, rv);
		rd(CA);
		chk_r("ctrl_reset", 16'h0000, rv);
		chk_s("oe_reset", 4'h0, port_pin_oe_o);
		// Settle first: enabling may itself register a change
		wr(CA, 16'h2200);
		repeat (6) @(negedge mclk_i);
		wr(SA, 16'h00f0);
		serial_host_model_inst.set_pins(4'h1);
		repeat (5) @(negedge mclk_i);
		rd(SA);
		chk_r("pin0_change", 16'h0011, rv);
		chk_s("irq_delta", 4'h1, irq4);
		wr(SA, 16'h0000);
		rd(SA);
		chk_r("zero_keeps", 16'h0011, rv);
		wr(SA, 16'h0010);
		rd(SA);
		chk_r("w1c", 16'h0001, rv);
		chk_s("irq_clear", 4'h0, irq4);
		wr(CA, 16'h2000);
		serial_host_model_inst.set_pins(4'h3);
		repeat (5) @(negedge mclk_i);
		rd(SA);
		chk_r("levels", 16'h0023, rv);
		chk_s("irq_masked", 4'h0, irq4);
		wr(CA, 16'h0000);
		serial_host_model_inst.set_pins(4'h7);
		repeat (5) @(negedge mclk_i);
		rd(SA);
		chk_r("in_reset", 16'h0020, rv & 16'h00f0);
		wr(CA, 16'h2008);
		wr(SA, 16'h00f0);
		serial_host_model_inst.set_pins(4'hf);
		wr(SA, 16'h0008);
		chk_s("drive_high", 4'h8, port_pin_o & port_pin_oe_o);
		// The driven pin toggles itself here, which must not raise its flag
		repeat (5) @(negedge mclk_i);
		rd(SA);
		chk_r("out_no_flag", 16'h0000, rv & 16'h0080);
		chk_r("out_level", 16'h0008, rv & 16'h0008);
		wr(SA, 16'h0000);
		chk_s("drive_low", 4'h0, port_pin_o & port_pin_oe_o);
		other_irq_i = 1'b1;
		@(negedge mclk_i);
		chk_s("irq_other", 4'h1, irq4);
		other_irq_i = 1'b0;
		wr(DA, 16'h0000);
		ticks(40);
		chk_r("ticks_div0", 16'h0000, k[15:0]);
		wr(DA, 16'h0003);
		repeat (4) @(negedge mclk_i);
		ticks(48);
		chk_r("ticks_div3", 16'h0010, k[15:0]);
		wr(DA, 16'h0001);
		wr(CA, 16'h2020);
		serial_host_model_inst.send_char(8'h41, 128);
		wait_irq;
		chk_s("irq_lock", 4'h1, irq4);
		rd(DA);
		chk_r("lock_div", 16'h0008, rv);
		rd(SA);
		chk_r("done", 16'h4000, rv & 16'h4000);
		chk_r("char", 16'h0041, {8'h00, char_data_o});
		repeat (50) @(negedge mclk_i);
		chk_s("irq_held", 4'h1, irq4);
		serial_host_model_inst.send_char(8'h61, 128);
		repeat (20) @(negedge mclk_i);
		rd(SA);
		chk_r("overrun", 16'h0200, rv & 16'h0200);
		wr(CA, 16'h2000);
		wr(SA, 16'h4200);
		char_read_i = 1'b1;
		@(negedge mclk_i);
		char_read_i = 1'b0;
		rd(SA);
		chk_r("cleared", 16'h0000, rv & 16'h4300);
		chk_s("irq_quiet", 4'h0, irq4);
		wr(CA, 16'h2020);
		serial_host_model_inst.send_char(8'h61, 80);
		wait_irq;
		rd(DA);
		chk_r("lock_lower", 16'h0005, rv);
		complete_run;
	end
endmodule
`default_nettype wire
